// *** bench/plld_monitor.sv ***
// Purpose: port assertions for plld_top
// Assumes: no lock window is wider than 12000 ps
// Notes: all properties sample on clk and sleep in reset
`timescale 1ns/1ns
module plld_monitor (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// serial port
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic sdio_out,
	input wire logic sdio_oe,
	// detector and controls
	input wire logic pfd_tick,
	input wire logic [15:0] phase_err_ps,
	input wire logic ref_present,
	input wire logic lock_detect,
	input wire logic vco_regulator_off,
	input wire logic [1:0] reserved_output_field
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	sequence s_far_tick;
		pfd_tick && phase_err_ps > 16'h2ee0;
	endsequence
	sequence s_cs_idle;
		cs_n [*2];
	endsequence
	property p_drop_far;
		lock_detect ##0 s_far_tick |-> ##2 !lock_detect;
	endproperty
	a_drop_far: assert property (p_drop_far) else $error("no drop");
	property p_rise_tick;
		$rose(lock_detect) |-> $past(pfd_tick, 2);
	endproperty
	a_rise_tick: assert property (p_rise_tick) else $error("no tick");
	property p_rise_win;
		$rose(lock_detect) |-> $past(phase_err_ps, 2) <= 16'h2ee0;
	endproperty
	a_rise_win: assert property (p_rise_win) else $error("far lock");
	property p_hold;
		lock_detect && !$past(pfd_tick) && $past(ref_present) |=> lock_detect;
	endproperty
	a_hold: assert property (p_hold) else $error("lock lost");
	property p_rst_val;
		$fell(rst) |-> vco_regulator_off && !lock_detect
			&& reserved_output_field == 2'h1;
	endproperty
	a_rst_val: assert property (p_rst_val) else $error("reset value");
	property p_oe_idle;
		s_cs_idle |-> !sdio_oe;
	endproperty
	a_oe_idle: assert property (p_oe_idle) else $error("oe idle");
	property p_oe_rise;
		$rose(sdio_oe) |-> !cs_n && !sclk;
	endproperty
	a_oe_rise: assert property (p_oe_rise) else $error("oe rise");
	property p_out_chg;
		$changed(sdio_out) |-> !sclk && !$past(sclk);
	endproperty
	a_out_chg: assert property (p_out_chg) else $error("out moved");
endmodule : plld_monitor

bind plld_top plld_monitor u_mon (.clk(clk), .rst(rst), .cs_n(cs_n),
	.sclk(sclk), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
	.pfd_tick(pfd_tick), .phase_err_ps(phase_err_ps),
	.ref_present(ref_present), .lock_detect(lock_detect),
	.vco_regulator_off(vco_regulator_off),
	.reserved_output_field(reserved_output_field));

// *** bench/plld_top_tb.sv ***
// Purpose: random and corner tests of plld_top
// Assumes: lock counts shrunk to 4, 5, 6 and 8
// Notes: inputs change on the falling clock edge
`timescale 1ns/1ns
`include "plld_cfg.svh"
module plld_top_tb;
	logic clk, rst, cs_n, sclk, tb_sd, pfd_tick, ref_present;
	logic sdio_out, sdio_oe, lock_detect, bleed_on, vco_regulator_off;
	logic [1:0] reserved_output_field, c;
	logic [15:0] phase_err_ps, w;
	logic [31:0] seed = 32'h44;
	logic [7:0] rd, v;
	int err_count = 0;
	int n_tests = 0;
	// shared data line: design drives it only while enabled
	wire sdio_in = sdio_oe ? sdio_out : tb_sd;
	plld_top #(.LOCK_CYCLES0(14'h4), .LOCK_CYCLES1(14'h5),
		.LOCK_CYCLES2(14'h6), .LOCK_CYCLES3(14'h8)) DUT (.clk(clk),
		.rst(rst), .cs_n(cs_n), .sclk(sclk), .sdio_in(sdio_in),
		.sdio_out(sdio_out), .sdio_oe(sdio_oe), .pfd_tick(pfd_tick),
		.phase_err_ps(phase_err_ps), .ref_present(ref_present),
		.lock_detect(lock_detect), .bleed_on(bleed_on),
		.vco_regulator_off(vco_regulator_off),
		.reserved_output_field(reserved_output_field));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic logic [15:0] win(input logic [1:0] b, input logic p);
		logic [31:0] d;
		d = b == 2'h0 ? 32'h1388 : b == 2'h1 ? 32'h1770 :
			b == 2'h2 ? 32'h1f40 : 32'h2ee0;
		return 16'(p ? d * 32'h18 / 32'h32 : d);
	endfunction : win
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : complete_run
	// one whole frame, msb first; read bits follow each sclk fall
	task automatic xfer(input logic [23:0] f);
		cs_n = 1'b0;
		@(negedge clk);
		for (int i = 23; i >= 0; i--) begin
			tb_sd = f[i];
			sclk = 1'b1;
			repeat (2) @(negedge clk);
			sclk = 1'b0;
			repeat (2) @(negedge clk);
			// sample the shared line, so a missing drive enable shows
			if (i > 0 && i < 9) rd[i - 1] = sdio_in;
			if (i == 1) chk(8'(sdio_oe), 8'(f[23]));
		end
		cs_n = 1'b1;
		repeat (4) @(negedge clk);
	endtask : xfer
	task automatic ticks(input int n, input logic [15:0] lo, hi);
		for (int k = 0; k < n; k++) begin
			pfd_tick = 1'b1;
			phase_err_ps = k == 0 ? hi : lo + 16'(rnd() % (32'(hi - lo) + 1));
			@(negedge clk);
		end
		pfd_tick = 1'b0;
		repeat (2) @(negedge clk);
	endtask : ticks
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		{rst, cs_n, sclk, tb_sd, pfd_tick, ref_present} = 6'h31;
		phase_err_ps = 16'h0;
		repeat (12) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		chk(8'({vco_regulator_off, reserved_output_field, lock_detect}),
			8'ha);
		xfer({1'b1, `PLLD_ADDR_LOCK_BLEED, 8'h0});
		chk(rd, `PLLD_RST_LOCK_BLEED);
		xfer({1'b1, `PLLD_ADDR_LOCK_COUNT, 8'h0});
		chk(rd, `PLLD_RST_LOCK_COUNT);
		xfer({1'b1, 15'h29, 8'h0});
		chk(rd, 8'h0);
		$display("done: reset values");
		for (int k = 0; k < 4; k++) begin
			v = 8'(rnd());
			xfer({1'b0, `PLLD_ADDR_LOCK_BLEED, v});
			xfer({1'b1, `PLLD_ADDR_LOCK_BLEED, 8'h0});
			chk(rd, v);
			chk(8'({vco_regulator_off, reserved_output_field}), 8'(v[2:0]));
			chk(8'(bleed_on), 8'(v[3] & ~v[4]));
			xfer({1'b0, `PLLD_ADDR_LOCK_COUNT, v});
			xfer({1'b1, `PLLD_ADDR_LOCK_COUNT, 8'h0});
			chk(rd, v & 8'h7);
		end
		$display("done: register access");
		for (int k = 0; k < 8; k++) begin
			// every count code twice over the eight passes
			c = 2'(k) ^ 2'(k >> 2);
			w = win(2'(k >> 1), k[0]);
			xfer({1'b0, `PLLD_ADDR_LOCK_COUNT, 5'h0, c, 1'b1});
			xfer({1'b0, `PLLD_ADDR_LOCK_BLEED, 2'(k >> 1), k[0], 5'h1d});
			// one short of lock, then a far tick must throw the count away
			ticks(c == 2'h3 ? 7 : 3 + int'(c), 16'h0, w);
			ticks(1, w + 16'h1, w + 16'h1);
			ticks(c == 2'h3 ? 7 : 3 + int'(c), 16'h0, w);
			chk(8'({lock_detect, bleed_on}), 8'h0);
			ticks(1, 16'h0, w);
			chk(8'({lock_detect, bleed_on}), 8'h3);
			ticks(1, w + 16'h1, w + 16'h1);
			chk(8'({lock_detect, bleed_on}), 8'h0);
		end
		$display("done: lock window and count");
		for (int k = 0; k < 2; k++) begin
			xfer({1'b0, `PLLD_ADDR_LOCK_COUNT, 7'h0, k == 0});
			xfer({1'b0, `PLLD_ADDR_LOCK_BLEED, 8'hc8});
			ticks(1, 16'h2ee1, 16'h2ee1);
			ticks(4, 16'h0, 16'h2ee0);
			ref_present = 1'b0;
			repeat (3) @(negedge clk);
			chk(8'({lock_detect, bleed_on}), 8'({k == 1, 1'b1}));
			ref_present = 1'b1;
		end
		xfer({1'b0, `PLLD_ADDR_LOCK_BLEED, 8'hc0});
		chk(8'({bleed_on, vco_regulator_off}), 8'h0);
		$display("done: loss of lock");
		complete_run();
	end
endmodule : plld_top_tb

// *** rtl/plld_cfg.svh ***
// Purpose: constants of the lock detector and bleed control block
// Assumes: byte wide registers, 15 bit serial addresses
// Notes: times are in picoseconds
`ifndef PLLD_CFG_SVH
`define PLLD_CFG_SVH

// ----------------------------------------------------------------
// register offsets and reset values
// ----------------------------------------------------------------
`define PLLD_ADDR_LOCK_BLEED 15'h0027
`define PLLD_ADDR_LOCK_COUNT 15'h0028
`define PLLD_RST_LOCK_BLEED 8'hc5
`define PLLD_RST_LOCK_COUNT 8'h03

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PLLD_BIAS_MSB 7
`define PLLD_BIAS_LSB 6
`define PLLD_PREC_BIT 5
`define PLLD_GATE_BIT 4
`define PLLD_BLEED_BIT 3
`define PLLD_VCO_OFF_BIT 2
`define PLLD_RSV_MSB 1
`define PLLD_RSV_LSB 0
`define PLLD_CNT_MSB 2
`define PLLD_CNT_LSB 1
`define PLLD_LOL_BIT 0
`define PLLD_CNT_REG_MASK 8'h07

// ----------------------------------------------------------------
// lock window times
// ----------------------------------------------------------------
`define PLLD_DELAY0_PS 16'd5000
`define PLLD_DELAY1_PS 16'd6000
`define PLLD_DELAY2_PS 16'd8000
`define PLLD_DELAY3_PS 16'd12000
`define PLLD_PREC_FRAC_PS 16'd5000
`define PLLD_PREC_INT_PS 16'd2400

// ----------------------------------------------------------------
// serial frame
// ----------------------------------------------------------------
`define PLLD_HDR_LAST 5'd15
`define PLLD_FRAME_LAST 5'd23

`endif

// *** rtl/plld_pkg.sv ***
// Purpose: types of the lock detector and bleed control block
// Assumes: nothing beyond the cfg header
// Notes: field order follows the two registers, msb first
package plld_pkg;

	typedef struct packed {
		logic [1:0] bias;
		logic precision;
		logic gate;
		logic bleed_en;
		logic vco_off;
		logic [1:0] rsv_out;
	} plld_ctrl_t;

	typedef struct packed {
		logic [1:0] count_sel;
		logic loss_of_lock_enable;
	} plld_count_t;

	typedef enum logic {
		plld_st_search,
		plld_st_locked
	} plld_state_t;

endpackage : plld_pkg

// *** rtl/plld_top.sv ***
// Purpose: digital lock detector, bleed gating, regulator control
// Assumes: all inputs synchronous to clk, one pfd_tick per comparison
// Notes: 3-wire port: cs_n low frames, sclk, shared sdio data line
`timescale 1ns/1ns
`include "plld_cfg.svh"

module plld_top #(
	parameter int CNT_W = 14,
	parameter logic [13:0] LOCK_CYCLES0 = 14'd1024,
	parameter logic [13:0] LOCK_CYCLES1 = 14'd2048,
	parameter logic [13:0] LOCK_CYCLES2 = 14'd4096,
	parameter logic [13:0] LOCK_CYCLES3 = 14'd8192
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// serial register port
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic sdio_in,
	output logic sdio_out,
	output logic sdio_oe,
	// phase detector side
	input wire logic pfd_tick,
	input wire logic [15:0] phase_err_ps,
	input wire logic ref_present,
	// controls and status
	output logic lock_detect,
	output logic bleed_on,
	output logic vco_regulator_off,
	output logic [1:0] reserved_output_field
);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [15:0] window_ps(input logic [1:0] bias,
			input logic precision);
		logic [31:0] d;
		logic [31:0] p;
		d = 32'd0;
		p = 32'd0;
		case (bias)
			2'h0: d = {16'h0000, `PLLD_DELAY0_PS};
			2'h1: d = {16'h0000, `PLLD_DELAY1_PS};
			2'h2: d = {16'h0000, `PLLD_DELAY2_PS};
			default: d = {16'h0000, `PLLD_DELAY3_PS};
		endcase
		// integer precision narrows the window by the same ratio
		p = precision ? {16'h0000, `PLLD_PREC_INT_PS} :
			{16'h0000, `PLLD_PREC_FRAC_PS};
		window_ps = 16'((d * p) / {16'h0000, `PLLD_PREC_FRAC_PS});
	endfunction : window_ps

	function automatic logic [CNT_W-1:0] lock_target(input logic [1:0] sel);
		case (sel)
			2'h0: lock_target = CNT_W'(LOCK_CYCLES0);
			2'h1: lock_target = CNT_W'(LOCK_CYCLES1);
			2'h2: lock_target = CNT_W'(LOCK_CYCLES2);
			default: lock_target = CNT_W'(LOCK_CYCLES3);
		endcase
	endfunction : lock_target

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	plld_pkg::plld_ctrl_t ctrl;
	plld_pkg::plld_count_t cnt_cfg;
	logic sclk_q;
	logic [4:0] bit_cnt;
	logic [15:0] shift_in;
	logic [15:0] hdr;
	logic [7:0] rd_shift;
	logic reading;
	logic wr_strobe;
	logic [14:0] wr_addr;
	logic [7:0] wr_data;
	plld_pkg::plld_state_t state;
	logic [CNT_W-1:0] win_cnt;

	wire logic sclk_rise = sclk & ~sclk_q & ~cs_n;
	wire logic sclk_fall = ~sclk & sclk_q & ~cs_n;

	function automatic logic [7:0] read_reg(input logic [14:0] addr,
			input plld_pkg::plld_ctrl_t c, input plld_pkg::plld_count_t k);
		case (addr)
			`PLLD_ADDR_LOCK_BLEED: read_reg = c;
			`PLLD_ADDR_LOCK_COUNT: read_reg = {5'h00, k};
			default: read_reg = 8'h00;
		endcase
	endfunction : read_reg

	// ------------------------------------------------------------
	// serial framing
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sclk_q <= 1'b0;
			bit_cnt <= 5'h00;
			shift_in <= 16'h0000;
			hdr <= 16'h0000;
			wr_strobe <= 1'b0;
			wr_addr <= 15'h0000;
			wr_data <= 8'h00;
		end else begin
			sclk_q <= sclk;
			wr_strobe <= 1'b0;
			if (cs_n) begin
				bit_cnt <= 5'h00;
			end else if (sclk_rise) begin
				shift_in <= {shift_in[14:0], sdio_in};
				if (bit_cnt != 5'h1f) begin
					bit_cnt <= bit_cnt + 5'h01;
				end
				if (bit_cnt == `PLLD_HDR_LAST) begin
					hdr <= {shift_in[14:0], sdio_in};
				end
				// extra clocks past one frame are ignored
				if (bit_cnt == `PLLD_FRAME_LAST && !hdr[15]) begin
					wr_strobe <= 1'b1;
					wr_addr <= hdr[14:0];
					wr_data <= {shift_in[6:0], sdio_in};
				end
			end
		end
	end

	// ------------------------------------------------------------
	// readback drive, data changes on falling sclk
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_shift <= 8'h00;
			reading <= 1'b0;
			sdio_out <= 1'b0;
			sdio_oe <= 1'b0;
		end else if (cs_n) begin
			reading <= 1'b0;
			sdio_oe <= 1'b0;
		end else if (sclk_rise && bit_cnt == `PLLD_HDR_LAST) begin
			reading <= shift_in[14];
			rd_shift <= read_reg({shift_in[13:0], sdio_in}, ctrl, cnt_cfg);
		end else if (sclk_fall && reading) begin
			sdio_oe <= (bit_cnt <= `PLLD_FRAME_LAST);
			sdio_out <= rd_shift[7];
			rd_shift <= {rd_shift[6:0], 1'b0};
		end
	end

	// ------------------------------------------------------------
	// register writes
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl <= `PLLD_RST_LOCK_BLEED;
			cnt_cfg <= 3'(`PLLD_RST_LOCK_COUNT);
		end else if (wr_strobe) begin
			if (wr_addr == `PLLD_ADDR_LOCK_BLEED) begin
				ctrl <= wr_data;
			end
			if (wr_addr == `PLLD_ADDR_LOCK_COUNT) begin
				cnt_cfg <= 3'(wr_data & `PLLD_CNT_REG_MASK);
			end
		end
	end

	// ------------------------------------------------------------
	// lock detector
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= plld_pkg::plld_st_search;
			win_cnt <= '0;
		end else begin
			case (state)
				plld_pkg::plld_st_search: begin
					if (pfd_tick) begin
						if (phase_err_ps > window_ps(ctrl.bias,
								ctrl.precision)) begin
							win_cnt <= '0;
						end else if (win_cnt >=
								lock_target(cnt_cfg.count_sel) - 1'b1) begin
							state <= plld_pkg::plld_st_locked;
							win_cnt <= '0;
						end else begin
							win_cnt <= win_cnt + 1'b1;
						end
					end
				end
				plld_pkg::plld_st_locked: begin
					// reference loss only counts once locked
					if (cnt_cfg.loss_of_lock_enable && !ref_present) begin
						state <= plld_pkg::plld_st_search;
					end else if (pfd_tick && phase_err_ps >
							window_ps(ctrl.bias, ctrl.precision)) begin
						state <= plld_pkg::plld_st_search;
					end
					win_cnt <= '0;
				end
				default: begin
					state <= plld_pkg::plld_st_search;
					win_cnt <= '0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// registered outputs
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lock_detect <= 1'b0;
			bleed_on <= 1'b0;
			vco_regulator_off <= 1'b1;
			reserved_output_field <= 2'h1;
		end else begin
			lock_detect <= (state == plld_pkg::plld_st_locked);
			// gating follows the lock detector state only while ctrl.gate is set
			bleed_on <= ctrl.bleed_en &
				(~ctrl.gate | (state == plld_pkg::plld_st_locked));
			vco_regulator_off <= ctrl.vco_off;
			reserved_output_field <= ctrl.rsv_out;
		end
	end

endmodule : plld_top
